// ===== design/cms_params.svh
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CMS_CLK_MHZ        125
`define CMS_TICK_US        1000
`define CMS_MS_PER_S       1000
`define CMS_END_DELAY_MS   30
`define CMS_FLASH_MS       250

// ----------------------------------------
// configuration limits and reset values
// ----------------------------------------
`define CMS_WIN_MIN_MS     1000
`define CMS_WIN_MAX_MS     16000
`define CMS_FACTOR_MIN     2
`define CMS_FACTOR_MAX     16
`define CMS_WIN_MS_RST     16'h0FA0
`define CMS_FACTOR_RST     5'h04
`define CMS_TIMEOUT_S_RST  16'h0258

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define CMS_OFF_CTRL       8'h00
`define CMS_OFF_WINDOW     8'h04
`define CMS_OFF_FACTOR     8'h08
`define CMS_OFF_TIMEOUT    8'h0C
`define CMS_OFF_STATUS     8'h10
`define CMS_OFF_IRQ_STAT   8'h14
`define CMS_OFF_IRQ_EN     8'h18
`define CMS_OFF_IRQ_CLR    8'h1C
`define CMS_CTRL_UNIDIR    0
`define CMS_EV_START       0
`define CMS_EV_END         1
`define CMS_EV_TIMEOUT     2
`define CMS_EV_REFUSE      3
`define CMS_RESP_OKAY      2'h0
`define CMS_RESP_SLVERR    2'h2

`endif

// ===== design/cms_pkg.sv
package cms_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_MUTING, ST_ENDING, ST_WAIT_LOW} cms_phase_type;
	typedef logic [1:0] cms_pair_type;
	typedef struct packed {
		logic        unidir;
		logic [15:0] window_ms;
		logic [4:0]  factor;
		logic [15:0] timeout_s;
	} cms_cfg_type;
	typedef struct packed {
		logic [2:0]    sync_a;
		logic [2:0]    sync_b;
		logic          in_a;
		logic          in_b;
		cms_phase_type phase;
		logic          first_b;
		logic [19:0]   tick_cnt;
		logic [13:0]   win_ms;
		logic [13:0]   delay_ms;
		logic [25:0]   mute_ms;
		logic [4:0]    end_ms;
		logic [7:0]    flash_ms;
		logic          forced_safe;
		cms_pair_type  pair;
		logic          lamp;
		logic          display;
		cms_pair_type  area;
		cms_cfg_type   cfg;
		logic [3:0]    irq_status;
		logic [3:0]    irq_en;
		logic          irq;
		logic          aw_have;
		logic [7:0]    awaddr;
		logic          w_have;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
	} cms_state_type;
endpackage : cms_pkg

// ===== design/cms_sequencer.sv
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "cms_params.svh"

// Behaviour
// - timeout while muting cancels it and forces the output pair to safe state
// - muting timeout is a software register with a delivered default
// - output pair stays on for the whole muting state
// - at most one muting area (input or output side) is active
// - no muting entry while an object is detected in the safety zone
// - muting shown on lamp output and on display output
// - muting starts when both inputs rise, either order, within window
// - activation window configurable from 1 to 16 seconds
// - bidirectional: muting ends at most 30 ms after an input falls
// - both modes end muting when the duration limit is reached
// - unidirectional: muting ends after measured delay times factor 2..16
// - lamp flashes while muting, off when muting ends
module cms_sequencer #(
	parameter int TICK_CYCLES = `CMS_TICK_US * `CMS_CLK_MHZ
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          ce,
	input  wire logic          muting_in_1,
	input  wire logic          muting_in_2,
	input  wire logic          object_detected,
	output cms_pkg::cms_pair_type safety_output_pair,
	output logic               muting_lamp,
	output logic               muting_display,
	output cms_pkg::cms_pair_type muting_area,
	output logic               irq,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [7:0]    awaddr,
	input  wire logic          wvalid,
	output logic               wready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	output logic               bvalid,
	input  wire logic          bready,
	output logic [1:0]         bresp,
	input  wire logic          arvalid,
	output logic               arready,
	input  wire logic [7:0]    araddr,
	output logic               rvalid,
	input  wire logic          rready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp
);
	import cms_pkg::*;

	cms_state_type s;
	cms_state_type next_s;
	logic          tick;
	logic          muting_now;
	logic          first_hi;
	logic          other_hi;
	logic          expired;
	logic          tmo_hit;
	logic          uni_hit;
	logic [3:0]    ev;
	logic [3:0]    clr;
	logic [32:0]   rd;
	logic [32:0]   rq;
	logic [31:0]   mask;
	logic [31:0]   wv;

	// ----------------------------------------
	// register read decode
	// ----------------------------------------
	function automatic logic [32:0] reg_read(input cms_state_type st, input logic [7:0] a);
		if (a == `CMS_OFF_CTRL) begin
			return {1'b1, 31'h0, st.cfg.unidir};
		end else if (a == `CMS_OFF_WINDOW) begin
			return {1'b1, 16'h0, st.cfg.window_ms};
		end else if (a == `CMS_OFF_FACTOR) begin
			return {1'b1, 27'h0, st.cfg.factor};
		end else if (a == `CMS_OFF_TIMEOUT) begin
			return {1'b1, 16'h0, st.cfg.timeout_s};
		end else if (a == `CMS_OFF_STATUS) begin
			return {1'b1, 26'h0, st.forced_safe, st.in_b, st.in_a, st.phase};
		end else if (a == `CMS_OFF_IRQ_STAT) begin
			return {1'b1, 28'h0, st.irq_status};
		end else if (a == `CMS_OFF_IRQ_EN) begin
			return {1'b1, 28'h0, st.irq_en};
		end else if (a == `CMS_OFF_IRQ_CLR) begin
			return {1'b1, 32'h0};
		end else begin
			return {1'b0, 32'h0};
		end
	endfunction : reg_read

	assign tick       = s.tick_cnt == 20'(TICK_CYCLES - 1);
	assign muting_now = s.phase == ST_MUTING || s.phase == ST_ENDING;
	assign first_hi   = s.first_b ? s.in_b : s.in_a;
	assign other_hi   = s.first_b ? s.in_a : s.in_b;
	assign expired    = 16'(s.win_ms) >= s.cfg.window_ms;
	assign tmo_hit    = s.mute_ms >= 26'(s.cfg.timeout_s) * 26'(`CMS_MS_PER_S);
	assign uni_hit    = s.mute_ms >= 26'(s.delay_ms) * 26'(s.cfg.factor);
	assign mask       = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};

	always_comb begin
		next_s = s;
		ev     = 4'h0;
		clr    = 4'h0;
		rd     = reg_read(s, s.awaddr);
		rq     = reg_read(s, araddr);
		wv     = (rd[31:0] & ~mask) | (s.wdata & mask);
		// ----------------------------------------
		// sensor inputs: third stage must agree with second before a change counts
		// ----------------------------------------
		next_s.sync_a = {s.sync_a[1:0], muting_in_1};
		next_s.sync_b = {s.sync_b[1:0], muting_in_2};
		if (s.sync_a[1] == s.sync_a[2]) next_s.in_a = s.sync_a[2];
		if (s.sync_b[1] == s.sync_b[2]) next_s.in_b = s.sync_b[2];
		next_s.tick_cnt = tick ? 20'h0 : s.tick_cnt + 20'h1;
		// ----------------------------------------
		// muting sequence
		// ----------------------------------------
		case (s.phase)
			ST_IDLE: begin
				if (s.in_a || s.in_b) begin
					next_s.phase   = ST_ARMED;
					next_s.first_b = s.in_b && !s.in_a;
					next_s.win_ms  = 14'h0;
				end
			end
			ST_ARMED: begin
				if (tick && s.win_ms != 14'h3FFF) next_s.win_ms = s.win_ms + 14'h1;
				if (other_hi) begin
					if (!first_hi || expired || object_detected) begin
						next_s.phase = ST_WAIT_LOW;
						ev[`CMS_EV_REFUSE] = 1'b1;
					end else begin
						next_s.phase    = ST_MUTING;
						next_s.delay_ms = s.win_ms;
						next_s.mute_ms  = 26'h0;
						ev[`CMS_EV_START] = 1'b1;
					end
				end else if (!first_hi) begin
					next_s.phase = ST_IDLE;
				end
			end
			ST_MUTING, ST_ENDING: begin
				if (tick) next_s.mute_ms = s.mute_ms + 26'h1;
				if (s.phase == ST_ENDING && tick) next_s.end_ms = s.end_ms + 5'h1;
				if (tmo_hit) begin
					next_s.phase       = ST_WAIT_LOW;
					next_s.forced_safe = 1'b1;
					ev[`CMS_EV_TIMEOUT] = 1'b1;
					ev[`CMS_EV_END]     = 1'b1;
				end else if (s.cfg.unidir) begin
					if (uni_hit) begin
						next_s.phase = ST_WAIT_LOW;
						ev[`CMS_EV_END] = 1'b1;
					end
				end else if (s.phase == ST_MUTING) begin
					if (!s.in_a || !s.in_b) begin
						next_s.phase  = ST_ENDING;
						next_s.end_ms = 5'h0;
					end
				end else if (tick && s.end_ms == 5'(`CMS_END_DELAY_MS - 1)) begin
					next_s.phase = ST_WAIT_LOW;
					ev[`CMS_EV_END] = 1'b1;
				end
			end
			ST_WAIT_LOW: begin
				if (!s.in_a && !s.in_b) begin
					next_s.phase       = ST_IDLE;
					next_s.forced_safe = 1'b0;
				end
			end
			default: begin
				next_s.phase = ST_WAIT_LOW;
			end
		endcase
		// ----------------------------------------
		// outputs, registered so they line up with the phase field
		// ----------------------------------------
		if (next_s.phase == ST_MUTING || next_s.phase == ST_ENDING) begin
			next_s.pair    = 2'h3;
			next_s.display = 1'b1;
			next_s.area    = next_s.first_b ? 2'h2 : 2'h1;
			if (!muting_now) begin
				next_s.lamp     = 1'b1;
				next_s.flash_ms = 8'h0;
			end else if (tick) begin
				if (s.flash_ms == 8'(`CMS_FLASH_MS - 1)) begin
					next_s.lamp     = !s.lamp;
					next_s.flash_ms = 8'h0;
				end else begin
					next_s.flash_ms = s.flash_ms + 8'h1;
				end
			end
		end else begin
			// the pair follows the detection input with one cycle of latency
			next_s.pair     = (!object_detected && !next_s.forced_safe) ? 2'h3 : 2'h0;
			next_s.display  = 1'b0;
			next_s.area     = 2'h0;
			next_s.lamp     = 1'b0;
			next_s.flash_ms = 8'h0;
		end
		// ----------------------------------------
		// bus slave
		// ----------------------------------------
		if (awvalid && awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr  = awaddr;
		end
		if (wvalid && wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata  = wdata;
			next_s.wstrb  = wstrb;
		end
		if (s.bvalid && bready) next_s.bvalid = 1'b0;
		if (s.aw_have && s.w_have) begin
			next_s.aw_have = 1'b0;
			next_s.w_have  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = rd[32] ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
			if (s.awaddr == `CMS_OFF_CTRL) begin
				next_s.cfg.unidir = wv[`CMS_CTRL_UNIDIR];
			end else if (s.awaddr == `CMS_OFF_WINDOW) begin
				// out-of-range values are clamped rather than refused
				if (wv < `CMS_WIN_MIN_MS) next_s.cfg.window_ms = 16'(`CMS_WIN_MIN_MS);
				else if (wv > `CMS_WIN_MAX_MS) next_s.cfg.window_ms = 16'(`CMS_WIN_MAX_MS);
				else next_s.cfg.window_ms = wv[15:0];
			end else if (s.awaddr == `CMS_OFF_FACTOR) begin
				if (wv < `CMS_FACTOR_MIN) next_s.cfg.factor = 5'(`CMS_FACTOR_MIN);
				else if (wv > `CMS_FACTOR_MAX) next_s.cfg.factor = 5'(`CMS_FACTOR_MAX);
				else next_s.cfg.factor = wv[4:0];
			end else if (s.awaddr == `CMS_OFF_TIMEOUT) begin
				next_s.cfg.timeout_s = (wv[15:0] == 16'h0) ? 16'h1 : wv[15:0];
			end else if (s.awaddr == `CMS_OFF_IRQ_EN) begin
				next_s.irq_en = wv[3:0];
			end else if (s.awaddr == `CMS_OFF_IRQ_CLR) begin
				clr = wv[3:0];
			end
		end
		if (s.rvalid && rready) next_s.rvalid = 1'b0;
		if (arvalid && arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rq[31:0];
			next_s.rresp  = rq[32] ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
		end
		// an event in the same cycle as its clear keeps the bit set
		next_s.irq_status = (s.irq_status & ~clr) | ev;
		next_s.irq        = |(next_s.irq_status & next_s.irq_en);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s               <= '0;
			s.phase         <= ST_IDLE;
			s.cfg.window_ms <= `CMS_WIN_MS_RST;
			s.cfg.factor    <= `CMS_FACTOR_RST;
			s.cfg.timeout_s <= `CMS_TIMEOUT_S_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign safety_output_pair = s.pair;
	assign muting_lamp        = s.lamp;
	assign muting_display     = s.display;
	assign muting_area        = s.area;
	assign irq                = s.irq;
	assign awready            = !s.aw_have && !s.bvalid;
	assign wready             = !s.w_have && !s.bvalid;
	assign bvalid             = s.bvalid;
	assign bresp              = s.bresp;
	assign arready            = !s.rvalid;
	assign rvalid             = s.rvalid;
	assign rdata              = s.rdata;
	assign rresp              = s.rresp;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_end_last_ms;
		ce && tick && s.phase == ST_ENDING && !tmo_hit && !s.cfg.unidir
			&& s.end_ms == 5'(`CMS_END_DELAY_MS - 1);
	endsequence
	sequence s_left_wait;
		s.phase != ST_WAIT_LOW ##0 $past(s.phase) == ST_WAIT_LOW;
	endsequence

	property p_timeout;
		ce && muting_now && tmo_hit |=> s.phase == ST_WAIT_LOW && s.forced_safe
			&& safety_output_pair == 2'h0 && !muting_lamp;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not cancel muting");
	property p_pair_on;
		muting_now |-> safety_output_pair == 2'h3;
	endproperty
	a_pair_on: assert property (p_pair_on) else $error("pair off during muting");
	property p_one_area;
		$onehot0(muting_area) && (muting_now == (muting_area != 2'h0));
	endproperty
	a_one_area: assert property (p_one_area) else $error("muting area not exclusive");
	property p_no_entry_on_object;
		$rose(muting_display) |-> !$past(object_detected) && $past(s.phase) == ST_ARMED;
	endproperty
	a_no_entry_on_object: assert property (p_no_entry_on_object) else $error("entry with object");
	property p_display;
		muting_display == muting_now;
	endproperty
	a_display: assert property (p_display) else $error("display differs from muting state");
	property p_window;
		$rose(muting_now) |-> 16'($past(s.win_ms)) < s.cfg.window_ms;
	endproperty
	a_window: assert property (p_window) else $error("entry outside activation window");
	property p_cfg_range;
		s.cfg.window_ms >= 16'(`CMS_WIN_MIN_MS) && s.cfg.window_ms <= 16'(`CMS_WIN_MAX_MS)
			&& s.cfg.factor >= 5'(`CMS_FACTOR_MIN) && s.cfg.factor <= 5'(`CMS_FACTOR_MAX);
	endproperty
	a_cfg_range: assert property (p_cfg_range) else $error("configuration out of range");
	property p_end_delay;
		s_end_last_ms |=> s.phase == ST_WAIT_LOW && !muting_lamp;
	endproperty
	a_end_delay: assert property (p_end_delay) else $error("bidirectional end late");
	property p_end_ms_bound;
		s.phase == ST_ENDING |-> s.end_ms < 5'(`CMS_END_DELAY_MS);
	endproperty
	a_end_ms_bound: assert property (p_end_ms_bound) else $error("end delay overrun");
	property p_uni_end;
		ce && s.phase == ST_MUTING && s.cfg.unidir && uni_hit |=> !muting_now;
	endproperty
	a_uni_end: assert property (p_uni_end) else $error("unidirectional end missed");
	property p_lamp_off;
		!muting_now |-> !muting_lamp;
	endproperty
	a_lamp_off: assert property (p_lamp_off) else $error("lamp on outside muting");
	property p_wait_low;
		s_left_wait |-> $past(!s.in_a && !s.in_b);
	endproperty
	a_wait_low: assert property (p_wait_low) else $error("new cycle before inputs low");
endmodule : cms_sequencer

// ===== tb/cms_sensor_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// two muting sensors and the lamp watcher
// ----------------------------------------
module cms_sensor_model #(
	parameter int LAG = 2
) (
	input  wire logic clk,
	input  wire logic beam_1,
	input  wire logic beam_2,
	input  wire logic lamp,
	output logic      muting_in_1,
	output logic      muting_in_2,
	output int        lamp_edges
);
	logic [7:0] pipe_1 = 8'h00;
	logic [7:0] pipe_2 = 8'h00;
	logic       lamp_q = 1'b0;

	initial lamp_edges = 0;
	// a sensor answers LAG+1 cycles after the beam is broken, like a slow optical switch
	// beam 1 drives input 1 and beam 2 drives input 2; either beam may be broken first
	always @(posedge clk) begin
		pipe_1 <= {pipe_1[6:0], beam_1};
		pipe_2 <= {pipe_2[6:0], beam_2};
		lamp_q <= lamp;
		if (lamp !== lamp_q) begin
			lamp_edges <= lamp_edges + 1;
		end
	end
	assign muting_in_1 = pipe_1[LAG];
	assign muting_in_2 = pipe_2[LAG];
endmodule : cms_sensor_model

// ===== tb/cms_sequencer_tb.sv
`timescale 1ns/1ns
module cms_sequencer_tb;
	import cms_pkg::*;
	localparam int TK = 10;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, object_detected = 1'b0;
	logic beam_1 = 1'b0, beam_2 = 1'b0, muting_in_1, muting_in_2;
	cms_pair_type safety_output_pair, muting_area;
	logic muting_lamp, muting_display, irq;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int lamp_edges, fail_count = 0, check_count = 0;

	always #4 clk = ~clk;

	cms_sequencer #(.TICK_CYCLES(TK)) DUT (.clk(clk), .rstn(rstn), .ce(ce),
		.muting_in_1(muting_in_1), .muting_in_2(muting_in_2),
		.object_detected(object_detected), .safety_output_pair(safety_output_pair),
		.muting_lamp(muting_lamp), .muting_display(muting_display),
		.muting_area(muting_area), .irq(irq), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));
	cms_sensor_model #(.LAG(3)) sensors (.clk(clk), .beam_1(beam_1), .beam_2(beam_2),
		.lamp(muting_lamp), .muting_in_1(muting_in_1), .muting_in_2(muting_in_2),
		.lamp_edges(lamp_edges));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask : chk

	task automatic wait_disp(input logic v, input int lim, output int n);
		n = 0;
		@(negedge clk);
		while (muting_display !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) begin
			$display("ERROR display expected %b seen %b", v, muting_display);
			fail_count++;
			give_verdict();
		end
	endtask : wait_disp

	task automatic beams(input logic b1, input logic b2, input int gap);
		@(posedge clk);
		beam_1 <= b1;
		repeat (gap) @(posedge clk);
		beam_2 <= b2;
	endtask : beams

	// ----------------------------------------
	// register bus master
	// ----------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok, b_ok;
		b_ok = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !b_ok; n++) begin
			@(negedge clk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid && bready;
			@(posedge clk);
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			if (b_ok) bready <= 1'b0;
		end
		if (!b_ok) begin
			chk("write response", 1, 0);
			give_verdict();
		end
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_ok, r_ok;
		r_ok = 1'b0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !r_ok; n++) begin
			@(negedge clk);
			ar_ok = arvalid && arready;
			r_ok = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar_ok) arvalid <= 1'b0;
			if (r_ok) rready <= 1'b0;
		end
		if (!r_ok) begin
			chk("read response", 1, 0);
			give_verdict();
		end
	endtask : axr

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(nm, exp, d);
		chk({nm, " resp"}, 32'(`CMS_RESP_OKAY), 32'(r));
	endtask : rchk

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		int n;
		rchk("window", `CMS_OFF_WINDOW, 32'h0FA0);
		rchk("factor", `CMS_OFF_FACTOR, 32'h4);
		rchk("timeout", `CMS_OFF_TIMEOUT, 32'h258);
		rchk("ctrl", `CMS_OFF_CTRL, 32'h0);
		axr(8'h40, d, r);
		chk("unmapped resp", 32'(`CMS_RESP_SLVERR), 32'(r));
		chk("unmapped data", 32'h0, d);
		axw(`CMS_OFF_WINDOW, 32'h1F4);
		rchk("window low clamp", `CMS_OFF_WINDOW, 32'h3E8);
		axw(`CMS_OFF_WINDOW, 32'h0FA0);
		axw(`CMS_OFF_IRQ_EN, 32'h7);
		chk("pair on", 2'b11, safety_output_pair);
		$display("test reset done");
	endtask : t_reset

	task automatic t_bidir(input logic rev);
		int n;
		if (rev) beams(1'b0, 1'b1, 0);
		beams(1'b1, 1'b1, 5 * TK);
		wait_disp(1'b1, 40, n);
		chk("area", rev ? 2'b10 : 2'b01, muting_area);
		chk("lamp on", 1'b1, muting_lamp);
		@(posedge clk) object_detected <= 1'b1;
		repeat (30) @(negedge clk);
		chk("pair muted", 2'b11, safety_output_pair);
		chk("irq start", 1'b1, irq);
		@(posedge clk) object_detected <= 1'b0;
		@(posedge clk) beam_1 <= 1'b0;
		wait_disp(1'b0, 31 * TK + 20, n);
		chk("end soon", 1'b1, n > 20 * TK);
		chk("lamp off", 1'b0, muting_lamp);
		chk("area off", 2'b00, muting_area);
		beams(1'b0, 1'b0, 0);
		axw(`CMS_OFF_IRQ_CLR, 32'hF);
		chk("irq cleared", 1'b0, irq);
		$display("test bidirectional done");
	endtask : t_bidir

	task automatic t_refuse();
		@(posedge clk) object_detected <= 1'b1;
		beams(1'b1, 1'b1, 2 * TK);
		repeat (60) @(negedge clk);
		chk("no mute on object", 1'b0, muting_display);
		rchk("refused flag", `CMS_OFF_IRQ_STAT, 32'h8);
		chk("masked irq", 1'b0, irq);
		axw(`CMS_OFF_IRQ_EN, 32'hF);
		chk("unmasked irq", 1'b1, irq);
		axw(`CMS_OFF_IRQ_CLR, 32'hF);
		chk("irq low", 1'b0, irq);
		@(posedge clk) object_detected <= 1'b0;
		beams(1'b0, 1'b0, 0);
		axw(`CMS_OFF_WINDOW, 32'h3E8);
		beams(1'b1, 1'b1, 1010 * TK);
		repeat (60) @(negedge clk);
		chk("late second rise", 1'b0, muting_display);
		chk("pair protecting", 2'b11, safety_output_pair);
		beams(1'b0, 1'b0, 0);
		axw(`CMS_OFF_IRQ_CLR, 32'hF);
		$display("test refusal done");
	endtask : t_refuse

	// sensors stay blocked, as when material leaves the danger zone slowly
	task automatic t_unidir();
		int n;
		axw(`CMS_OFF_CTRL, 32'h1);
		axw(`CMS_OFF_FACTOR, 32'h2);
		beams(1'b1, 1'b1, 20 * TK);
		wait_disp(1'b1, 40, n);
		wait_disp(1'b0, 60 * TK, n);
		chk("end after delay x2", 1'b1, n >= 38 * TK && n <= 42 * TK);
		beams(1'b1, 1'b0, 0);
		repeat (20) @(posedge clk);
		beams(1'b1, 1'b1, 0);
		repeat (60) @(negedge clk);
		chk("no restart", 1'b0, muting_display);
		beams(1'b0, 1'b0, 0);
		axw(`CMS_OFF_CTRL, 32'h0);
		axw(`CMS_OFF_IRQ_CLR, 32'hF);
		$display("test unidirectional done");
	endtask : t_unidir

	task automatic t_timeout();
		int n, e0;
		axw(`CMS_OFF_TIMEOUT, 32'h1);
		rchk("timeout set", `CMS_OFF_TIMEOUT, 32'h1);
		beams(1'b1, 1'b1, 5 * TK);
		wait_disp(1'b1, 40, n);
		e0 = lamp_edges;
		wait_disp(1'b0, 1100 * TK, n);
		chk("timeout length", 1'b1, n >= 990 * TK);
		chk("forced safe", 2'b00, safety_output_pair);
		chk("lamp flashed", 1'b1, lamp_edges - e0 >= 3);
		rchk("timeout flags", `CMS_OFF_IRQ_STAT, 32'h7);
		beams(1'b0, 1'b0, 0);
		repeat (40) @(negedge clk);
		chk("pair back", 2'b11, safety_output_pair);
		axw(`CMS_OFF_TIMEOUT, 32'h258);
		$display("test timeout done");
	endtask : t_timeout

	initial begin
		repeat (100000) @(posedge clk);
		chk("run time", 1, 0);
		give_verdict();
	end

	initial begin
		repeat (5) @(posedge clk);
		chk("pair in reset", 2'b00, safety_output_pair);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_bidir(1'b0);
		t_bidir(1'b1);
		t_refuse();
		t_unidir();
		t_timeout();
		give_verdict();
	end
endmodule : cms_sequencer_tb
